// ===== bench/phy_far_model.sv
/*
 Far-end link partner model: resolves link state from the config.
 Assumes the bench drives link presence, polarity and partner abilities.
*/
`timescale 1ns/1ps
module phy_far_model (
   input wire logic clk,
   input wire logic link_up,
   input wire logic pol,
   input wire logic [4:0] adv,
   input wire port_link_pkg::phy_cfg_t cfg,
   output port_link_pkg::phy_stat_t st
);
   logic [4:0] com;
   logic up;
   logic dup;
   assign com = adv & cfg.advert;
   assign up = link_up & ~cfg.power_down;
   assign dup = cfg.an_enable ? (com[3] | com[1]) : cfg.force_duplex;
   initial st = '0;
   always @(posedge clk) begin
      st.link_good <= up;
      st.negotiation_complete <= up & cfg.an_enable;
      st.an_speed <= up & (cfg.an_enable ? |com[3:2] : cfg.force_speed);
      st.an_duplex <= up & dup;
      st.rx_fc <= up & com[4] & dup;
      st.tx_fc <= up & com[4] & dup;
      st.mdix <= ~cfg.auto_cross_en & cfg.force_mdix;
      st.pol_rev <= up & pol;
      st.partner <= up ? adv : 5'h00;
   end
endmodule

// ===== bench/test_port_phy_control_status_regs.sv
/*
 Self-checking bench for the port link register bank.
 Assumes the package, the design and the far-end model are compiled.
*/
`timescale 1ns/1ps
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin n_errors++; \
$display("wrong value %s exp %h got %h", n, e, g); end end
module test_port_phy_control_status_regs;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic rd = 1'b0;
   logic wr = 1'b0;
   logic link_up = 1'b0;
   logic pol = 1'b0;
   logic wreq;
   logic irq;
   logic [7:0] adr = 8'h00;
   logic [31:0] wd = 32'h00000000;
   logic [31:0] rdat;
   logic [15:0] q16;
   port_link_pkg::phy_stat_t st;
   port_link_pkg::phy_cfg_t cfg;
   int n_errors = 0;
   int checked = 0;
   int cyc = 0;
   int pulses = 0;
   // Control write, then forced mdix, auto cross, loop, tx_off, power, masked bit 12
   logic [20:0] rows [8] = '{{16'h00FF, 5'h04}, {16'h02FF, 5'h04},
      {16'h06FF, 5'h02}, {16'h04FF, 5'h00}, {16'h01FF, 5'h05},
      {16'h40FF, 5'h14}, {16'h08FF, 5'h0C}, {16'h10FF, 5'h04}};
   always #2.5 clk = ~clk;
   port_phy_control_status_regs DUT (.clk(clk), .rst_b(rst_b),
      .avs_address(adr), .avs_read(rd), .avs_write(wr),
      .avs_writedata(wd), .avs_byteenable(4'h3), .avs_readdata(rdat),
      .avs_waitrequest(wreq), .phy_stat(st), .phy_cfg(cfg), .irq(irq));
   phy_far_model far_end (.clk(clk), .link_up(link_up), .pol(pol),
      .adv(5'h1F), .cfg(cfg), .st(st));
   // ***************************************************
   // Bus tasks and closing
   // ***************************************************
   task automatic bus(input logic w, input logic [7:0] a,
         input logic [15:0] d, output logic [15:0] r);
      @(posedge clk);
      adr <= a;
      wd <= {16'h0000, d};
      wr <= w;
      rd <= ~w;
      do @(posedge clk); while (wreq !== 1'b0);
      r = rdat[15:0];
      rd <= 1'b0;
      wr <= 1'b0;
   endtask
   task automatic rchk(input string n, input logic [7:0] a,
         input logic [15:0] e);
      bus(1'b0, a, 16'h0000, q16);
      `CHK(n, e, q16)
   endtask
   task automatic wait_stat(input logic [15:0] m, input logic [15:0] e);
      repeat (60) begin
         bus(1'b0, 8'h04, 16'h0000, q16);
         if ((q16 & m) === e) break;
      end
   endtask
   task automatic give_verdict;
      $display("checks %0d errors %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cfg.restart_an === 1'b1) pulses <= pulses + 1;
      if (cyc == 20000) begin
         n_errors++;
         give_verdict();
      end
   end
   // ***************************************************
   // Main sequence
   // ***************************************************
   initial begin
      repeat (3) @(posedge clk);
      rst_b <= 1'b1;
      rchk("ctrl rst", 8'h02, 16'h00FF);
      rchk("stat rst", 8'h04, 16'h8000);
      rchk("unmapped", 8'h10, 16'h0000);
      $display("test reset done");
      foreach (rows[i]) begin
         bus(1'b1, 8'h02, rows[i][20:5], q16);
         rchk("ctrl rd", 8'h02, rows[i][20:5] & 16'hEFFF);
         `CHK("cfg", rows[i][4:0], {cfg.tx_off, cfg.power_down,
            cfg.auto_cross_en, cfg.force_mdix & ~cfg.auto_cross_en,
            cfg.far_loop})
      end
      $display("test rows done");
      link_up <= 1'b1;
      bus(1'b1, 8'h02, 16'h062F, q16);
      wait_stat(16'h0020, 16'h0020);
      `CHK("an hold", 1'b1, cfg.an_enable)
      bus(1'b1, 8'h02, 16'h262F, q16);
      wait_stat(16'h0080, 16'h0080);
      `CHK("forced", 3'b001, {cfg.an_enable, cfg.force_speed,
         cfg.force_duplex})
      `CHK("restart", 1'b1, pulses > 0)
      rchk("f stat", 8'h04, 16'h82BF);
      $display("test forced done");
      pol <= 1'b1;
      bus(1'b1, 8'h02, 16'h2098, q16);
      wait_stat(16'h0040, 16'h0040);
      `CHK("advert", 5'h18, cfg.advert)
      rchk("an stat", 8'h04, 16'hBE7F);
      bus(1'b1, 8'h04, 16'h7FFF, q16);
      rchk("alt sel", 8'h04, 16'h3E7F);
      `CHK("alt cfg", 1'b0, cfg.alt_xalg)
      $display("test negotiation done");
      bus(1'b1, 8'h0C, 16'h0001, q16);
      bus(1'b0, 8'h08, 16'h0000, q16);
      link_up <= 1'b0;
      wait_stat(16'h0020, 16'h0000);
      `CHK("irq on", 1'b1, irq)
      bus(1'b0, 8'h08, 16'h0000, q16);
      `CHK("irq bit", 1'b1, q16[0])
      rchk("irq clr", 8'h08, 16'h0000);
      `CHK("irq off", 1'b0, irq)
      bus(1'b1, 8'h0C, 16'h0000, q16);
      link_up <= 1'b1;
      wait_stat(16'h0020, 16'h0020);
      `CHK("masked", 1'b0, irq)
      bus(1'b1, 8'h0C, 16'h0007, q16);
      rchk("mask rd", 8'h0C, 16'h0007);
      `CHK("unmask", 1'b1, irq)
      $display("test interrupt done");
      give_verdict();
   end
endmodule

// ===== design/port_phy_control_status_regs.sv
/*
 Per-port PHY control and status register bank, Avalon-MM slave.
 Assumes PHY status inputs arrive asynchronously and are synchronised.
*/
// Local design decision: the Avalon-MM register port.
`timescale 1ns/1ps
module port_phy_control_status_regs (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic [7:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire port_link_pkg::phy_stat_t phy_stat,
   output port_link_pkg::phy_cfg_t phy_cfg,
   output logic irq
);
   // ***************************************************
   // Bus decode
   // ***************************************************
   logic ack_r;
   logic [15:0] ctrl_r;
   logic [15:0] ctrl_nxt;
   logic alt_xalg_r;
   logic [2:0] irq_stat_r;
   logic [2:0] irq_stat_nxt;
   logic [2:0] irq_mask_r;
   logic [31:0] rdata_nxt;
   port_link_pkg::phy_stat_t s1_r;
   port_link_pkg::phy_stat_t s2_r;
   port_link_pkg::phy_stat_t prev_r;
   port_link_pkg::phy_cfg_t cfg_r;
   logic relink_r;
   wire req = (avs_read | avs_write) & ~ack_r;
   wire wr = avs_write & ack_r;
   wire rd = avs_read & ack_r;
   wire sel_ctrl = avs_address == port_link_pkg::CTRL_OFS;
   wire sel_stat = avs_address == port_link_pkg::STAT_OFS;
   wire sel_ist = avs_address == port_link_pkg::IRQ_STAT_OFS;
   wire sel_imask = avs_address == port_link_pkg::IRQ_MASK_OFS;
   wire be_lo = avs_byteenable[0];
   wire be_hi = avs_byteenable[1];
   wire [15:0] be_mask = {{8{be_hi}}, {8{be_lo}}};
   wire wr_ctrl = wr & sel_ctrl;
   wire wr_stat = wr & sel_stat & be_hi;
   wire rd_ist = rd & sel_ist;
   assign avs_waitrequest = (avs_read | avs_write) & ~ack_r;

   // ***************************************************
   // Control register
   // ***************************************************
   wire [15:0] wval = (avs_writedata[15:0] & be_mask) | (ctrl_r & ~be_mask);
   // Restart bit is a one-shot; clears after it is sent
   assign ctrl_nxt = wr_ctrl ? (wval & port_link_pkg::CTRL_WMASK)
      : (ctrl_r & port_link_pkg::RESTART_CLR);

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         ack_r <= 1'b0;
         ctrl_r <= port_link_pkg::CTRL_RST;
         alt_xalg_r <= 1'b1;
      end else begin
         ack_r <= req;
         ctrl_r <= ctrl_nxt;
         if (wr_stat) begin
            alt_xalg_r <= avs_writedata[port_link_pkg::B_ALT_XALG];
         end
      end
   end

   // ***************************************************
   // Applied configuration
   // ***************************************************
   // Advertising/forcing latch only on restart, link loss or the first cycle after reset
   wire link_fall = prev_r.link_good & ~s2_r.link_good;
   wire restart = ctrl_r[port_link_pkg::B_RESTART];
   wire apply = restart | link_fall | relink_r;
   port_link_pkg::phy_cfg_t cfg_nxt;
   assign cfg_nxt.tx_off = ctrl_r[port_link_pkg::B_TX_OFF];
   assign cfg_nxt.power_down = ctrl_r[port_link_pkg::B_PWR_DOWN];
   assign cfg_nxt.auto_cross_en = ~ctrl_r[port_link_pkg::B_NO_AUTOX];
   assign cfg_nxt.force_mdix = ctrl_r[port_link_pkg::B_NO_AUTOX]
      & ctrl_r[port_link_pkg::B_FORCE_MDIX];
   assign cfg_nxt.far_loop = ctrl_r[port_link_pkg::B_FAR_LOOP];
   assign cfg_nxt.alt_xalg = alt_xalg_r;
   assign cfg_nxt.an_enable = apply ? ctrl_r[port_link_pkg::B_AN_EN]
      : cfg_r.an_enable;
   assign cfg_nxt.restart_an = restart;
   assign cfg_nxt.advert = apply ? ctrl_r[4:0] : cfg_r.advert;
   assign cfg_nxt.force_speed = apply ? ctrl_r[port_link_pkg::B_F_SPEED]
      : cfg_r.force_speed;
   assign cfg_nxt.force_duplex = apply ? ctrl_r[port_link_pkg::B_F_DUPLEX]
      : cfg_r.force_duplex;
   assign phy_cfg = cfg_r;

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         cfg_r <= '0;
         relink_r <= 1'b1;
         s1_r <= '0;
         s2_r <= '0;
         prev_r <= '0;
      end else begin
         cfg_r <= cfg_nxt;
         relink_r <= 1'b0;
         s1_r <= phy_stat;
         s2_r <= s1_r;
         prev_r <= s2_r;
      end
   end

   // ***************************************************
   // Status composition
   // ***************************************************
   wire an_on = cfg_r.an_enable;
   wire an_ok = an_on & s2_r.negotiation_complete;
   wire op_speed = an_ok ? s2_r.an_speed : cfg_r.force_speed;
   wire op_duplex = an_ok ? s2_r.an_duplex : cfg_r.force_duplex;
   wire [15:0] stat_word = {alt_xalg_r, 1'b0, s2_r.pol_rev, s2_r.rx_fc,
      s2_r.tx_fc, s2_r.link_good & op_speed, s2_r.link_good & op_duplex,
      1'b0, s2_r.mdix, an_ok, s2_r.link_good, s2_r.partner};

   // ***************************************************
   // Interrupts
   // ***************************************************
   wire [2:0] ev = {prev_r.partner != s2_r.partner,
      ~prev_r.negotiation_complete & s2_r.negotiation_complete & an_on,
      prev_r.link_good != s2_r.link_good};
   // Event in the clearing cycle survives
   assign irq_stat_nxt = (rd_ist ? port_link_pkg::IRQ_ZERO : irq_stat_r) | ev;
   assign irq = |(irq_stat_r & irq_mask_r);

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         irq_stat_r <= port_link_pkg::IRQ_ZERO;
         irq_mask_r <= port_link_pkg::IRQ_MASK_RST;
      end else begin
         irq_stat_r <= irq_stat_nxt;
         if (wr & sel_imask & be_lo) begin
            irq_mask_r <= avs_writedata[2:0];
         end
      end
   end

   // ***************************************************
   // Read data
   // ***************************************************
   always_comb begin
      rdata_nxt = 32'h0000_0000;
      if (sel_ctrl) begin
         rdata_nxt[15:0] = ctrl_r;
      end else if (sel_stat) begin
         rdata_nxt[15:0] = stat_word;
      end else if (sel_ist) begin
         rdata_nxt[2:0] = irq_stat_r;
      end else if (sel_imask) begin
         rdata_nxt[2:0] = irq_mask_r;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         avs_readdata <= 32'h0000_0000;
      end else if (avs_read & ~ack_r) begin
         avs_readdata <= rdata_nxt;
      end
   end

   // ***************************************************
   // Assertions
   // ***************************************************
   property p_autox;
      @(posedge clk) disable iff (!rst_b)
      $past(rst_b) |->
         cfg_r.auto_cross_en == ~$past(ctrl_r[port_link_pkg::B_NO_AUTOX]);
   endproperty
   a_autox: assert property (p_autox) else $error("autox");
   property p_mdix;
      @(posedge clk) disable iff (!rst_b)
      cfg_r.force_mdix |-> $past(ctrl_r[10]) && $past(ctrl_r[9]);
   endproperty
   a_mdix: assert property (p_mdix) else $error("force mdix");
   property p_loop;
      @(posedge clk) disable iff (!rst_b)
      wr_ctrl ##1 1'b1 |=> cfg_r.far_loop == $past(ctrl_r[8]);
   endproperty
   a_loop: assert property (p_loop) else $error("loop");
   property p_restart;
      @(posedge clk) disable iff (!rst_b)
      ctrl_r[13] |=> !ctrl_r[13] || $past(wr_ctrl);
   endproperty
   a_restart: assert property (p_restart) else $error("restart");
   property p_hold;
      @(posedge clk) disable iff (!rst_b)
      !apply |=> $stable(cfg_r.advert);
   endproperty
   a_hold: assert property (p_hold) else $error("advert");
   property p_forced;
      @(posedge clk) disable iff (!rst_b)
      !cfg_r.an_enable |-> !stat_word[6]
         && (stat_word[10] == (s2_r.link_good & cfg_r.force_speed));
   endproperty
   a_forced: assert property (p_forced) else $error("forced");
   property p_rsvd;
      @(posedge clk) disable iff (!rst_b)
      !stat_word[14] && !stat_word[8];
   endproperty
   a_rsvd: assert property (p_rsvd) else $error("reserved");
   property p_rdack;
      @(posedge clk) disable iff (!rst_b)
      avs_read && !ack_r |=> !avs_waitrequest ##0 avs_readdata == $past(rdata_nxt);
   endproperty
   a_rdack: assert property (p_rdack) else $error("readdata");
   property p_partner;
      @(posedge clk) disable iff (!rst_b)
      stat_word[4:0] == s2_r.partner;
   endproperty
   a_partner: assert property (p_partner) else $error("partner");

   // ***************************************************
   // Bus handshake checks
   // ***************************************************
   property p_wait_first;
      @(posedge clk) disable iff (!rst_b)
      (avs_read || avs_write) && !ack_r |-> avs_waitrequest;
   endproperty
   a_wait_first: assert property (p_wait_first) else $error("wait first");

   property p_wait_second;
      @(posedge clk) disable iff (!rst_b)
      (avs_read || avs_write) && !ack_r |=> ack_r;
   endproperty
   a_wait_second: assert property (p_wait_second) else $error("wait end");

   property p_ack_one;
      @(posedge clk) disable iff (!rst_b)
      ack_r |=> !ack_r;
   endproperty
   a_ack_one: assert property (p_ack_one) else $error("ack width");

   property p_rd_hold;
      @(posedge clk) disable iff (!rst_b)
      !(avs_read && !ack_r) |=> $stable(avs_readdata);
   endproperty
   a_rd_hold: assert property (p_rd_hold) else $error("readdata hold");

   property p_unmapped;
      @(posedge clk) disable iff (!rst_b)
      avs_read && !ack_r && !(sel_ctrl || sel_stat || sel_ist || sel_imask)
         |=> avs_readdata == 32'h0000_0000;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read");

   property p_wr_other;
      @(posedge clk) disable iff (!rst_b)
      !wr_ctrl |=> ctrl_r == ($past(ctrl_r) & port_link_pkg::RESTART_CLR);
   endproperty
   a_wr_other: assert property (p_wr_other) else $error("ctrl held");

   property p_ctrl_wr;
      @(posedge clk) disable iff (!rst_b)
      wr_ctrl |=> ctrl_r == $past(wval & port_link_pkg::CTRL_WMASK);
   endproperty
   a_ctrl_wr: assert property (p_ctrl_wr) else $error("ctrl write");

   // ***************************************************
   // Applied configuration checks
   // ***************************************************
   property p_an_apply;
      @(posedge clk) disable iff (!rst_b)
      apply |=> cfg_r.an_enable == $past(ctrl_r[port_link_pkg::B_AN_EN]);
   endproperty
   a_an_apply: assert property (p_an_apply) else $error("an enable");

   property p_speed_apply;
      @(posedge clk) disable iff (!rst_b)
      apply |=> cfg_r.force_speed == $past(ctrl_r[port_link_pkg::B_F_SPEED]);
   endproperty
   a_speed_apply: assert property (p_speed_apply) else $error("speed");

   property p_duplex_apply;
      @(posedge clk) disable iff (!rst_b)
      apply |=>
         cfg_r.force_duplex == $past(ctrl_r[port_link_pkg::B_F_DUPLEX]);
   endproperty
   a_duplex_apply: assert property (p_duplex_apply) else $error("duplex");

   property p_advert_apply;
      @(posedge clk) disable iff (!rst_b)
      apply |=>
         cfg_r.advert == $past(ctrl_r[port_link_pkg::B_F_DUPLEX-1:0]);
   endproperty
   a_advert_apply: assert property (p_advert_apply) else $error("advert");

   property p_txoff;
      @(posedge clk) disable iff (!rst_b)
      cfg_r.tx_off == $past(ctrl_r[port_link_pkg::B_TX_OFF]);
   endproperty
   a_txoff: assert property (p_txoff) else $error("tx off");

   property p_pwr;
      @(posedge clk) disable iff (!rst_b)
      cfg_r.power_down == $past(ctrl_r[port_link_pkg::B_PWR_DOWN]);
   endproperty
   a_pwr: assert property (p_pwr) else $error("power down");

   property p_restart_pulse;
      @(posedge clk) disable iff (!rst_b)
      cfg_r.restart_an == $past(ctrl_r[port_link_pkg::B_RESTART]);
   endproperty
   a_restart_pulse: assert property (p_restart_pulse) else $error("restart out");

   property p_alt;
      @(posedge clk) disable iff (!rst_b)
      $past(rst_b) |-> cfg_r.alt_xalg == $past(alt_xalg_r);
   endproperty
   a_alt: assert property (p_alt) else $error("alt select");

   property p_alt_wr;
      @(posedge clk) disable iff (!rst_b)
      wr_stat |=>
         alt_xalg_r == $past(avs_writedata[port_link_pkg::B_ALT_XALG]);
   endproperty
   a_alt_wr: assert property (p_alt_wr) else $error("alt write");

   // ***************************************************
   // Status word checks
   // ***************************************************
   property p_alt_stat;
      @(posedge clk) disable iff (!rst_b)
      stat_word[port_link_pkg::B_ALT_XALG] == alt_xalg_r;
   endproperty
   a_alt_stat: assert property (p_alt_stat) else $error("alt status");

   property p_pol;
      @(posedge clk) disable iff (!rst_b)
      stat_word[port_link_pkg::B_POL_REV] == s2_r.pol_rev;
   endproperty
   a_pol: assert property (p_pol) else $error("polarity");

   property p_mdix_stat;
      @(posedge clk) disable iff (!rst_b)
      stat_word[port_link_pkg::B_MDIX] == s2_r.mdix;
   endproperty
   a_mdix_stat: assert property (p_mdix_stat) else $error("mdix status");

   property p_fc;
      @(posedge clk) disable iff (!rst_b)
      stat_word[port_link_pkg::B_RX_FC] == s2_r.rx_fc
         && stat_word[port_link_pkg::B_TX_FC] == s2_r.tx_fc;
   endproperty
   a_fc: assert property (p_fc) else $error("flow control");

   property p_an_speed;
      @(posedge clk) disable iff (!rst_b)
      an_ok |->
         stat_word[port_link_pkg::B_SPEED] == (s2_r.link_good & s2_r.an_speed);
   endproperty
   a_an_speed: assert property (p_an_speed) else $error("an speed");

   property p_link;
      @(posedge clk) disable iff (!rst_b)
      stat_word[port_link_pkg::B_LINK] == s2_r.link_good
         && stat_word[port_link_pkg::B_NEGOTIATION_COMPLETE]
         == (cfg_r.an_enable & s2_r.negotiation_complete);
   endproperty
   a_link: assert property (p_link) else $error("link status");

   property p_fail_dup;
      @(posedge clk) disable iff (!rst_b)
      cfg_r.an_enable && !s2_r.negotiation_complete |->
         stat_word[port_link_pkg::B_DUPLEX]
         == (s2_r.link_good & cfg_r.force_duplex);
   endproperty
   a_fail_dup: assert property (p_fail_dup) else $error("failed duplex");

   // ***************************************************
   // Interrupt checks
   // ***************************************************
   property p_set_wins;
      @(posedge clk) disable iff (!rst_b)
      |ev |=> (irq_stat_r & $past(ev)) == $past(ev);
   endproperty
   a_set_wins: assert property (p_set_wins) else $error("event lost");

   property p_clear;
      @(posedge clk) disable iff (!rst_b)
      rd_ist && ev == port_link_pkg::IRQ_ZERO
         |=> irq_stat_r == port_link_pkg::IRQ_ZERO;
   endproperty
   a_clear: assert property (p_clear) else $error("clear on read");

   c_wr: cover property (@(posedge clk) disable iff (!rst_b) wr_ctrl);
   c_rst: cover property (@(posedge clk) disable iff (!rst_b) restart);
   c_irq: cover property (@(posedge clk) disable iff (!rst_b) irq);
   c_an: cover property (@(posedge clk) disable iff (!rst_b) an_ok);
endmodule

// ===== pkg/port_link_pkg.sv
/*
 Port link control/status register map, field positions, reset values,
 and PHY-side config/status carrier types for the per-port register block.
 Assumes a 32-bit Avalon-MM slave with word addressing by byte address.
*/
package port_link_pkg;
   // ***************************************************
   // Register offsets (byte addresses)
   // ***************************************************
   localparam logic [7:0] CTRL_OFS = 8'h02;
   localparam logic [7:0] STAT_OFS = 8'h04;
   localparam logic [7:0] IRQ_STAT_OFS = 8'h08;
   localparam logic [7:0] IRQ_MASK_OFS = 8'h0C;
   localparam int CTRL_IDX = 2;
   localparam int STAT_IDX = 4;
   // ***************************************************
   // Field positions
   // ***************************************************
   localparam int B_TX_OFF = 14;
   localparam int B_RESTART = 13;
   localparam int B_PWR_DOWN = 11;
   localparam int B_NO_AUTOX = 10;
   localparam int B_FORCE_MDIX = 9;
   localparam int B_FAR_LOOP = 8;
   localparam int B_AN_EN = 7;
   localparam int B_F_SPEED = 6;
   localparam int B_F_DUPLEX = 5;
   localparam int B_ALT_XALG = 15;
   localparam int B_POL_REV = 13;
   localparam int B_RX_FC = 12;
   localparam int B_TX_FC = 11;
   localparam int B_SPEED = 10;
   localparam int B_DUPLEX = 9;
   localparam int B_MDIX = 7;
   localparam int B_NEGOTIATION_COMPLETE = 6;
   localparam int B_LINK = 5;
   // ***************************************************
   // Reset values and masks
   // ***************************************************
   localparam logic [15:0] CTRL_RST = 16'h00FF;
   localparam logic [15:0] CTRL_WMASK = 16'h6FFF;
   localparam logic [15:0] RESTART_CLR = 16'hDFFF;
   localparam logic [2:0] IRQ_ZERO = 3'h0;
   localparam logic [2:0] IRQ_MASK_RST = 3'h0;
   localparam int IRQ_LINK_CHG = 0;
   localparam int IRQ_NEGOTIATION_COMPLETE = 1;
   localparam int IRQ_PAGE = 2;
   // ***************************************************
   // Carrier types
   // ***************************************************
   typedef struct packed {
      logic tx_off;
      logic power_down;
      logic auto_cross_en;
      logic force_mdix;
      logic far_loop;
      logic alt_xalg;
      logic an_enable;
      logic restart_an;
      logic [4:0] advert;
      logic force_speed;
      logic force_duplex;
   } phy_cfg_t;
   typedef struct packed {
      logic pol_rev;
      logic rx_fc;
      logic tx_fc;
      logic mdix;
      logic link_good;
      logic negotiation_complete;
      logic an_speed;
      logic an_duplex;
      logic [4:0] partner;
   } phy_stat_t;
endpackage
